// [latch_link_checker.sv]
// Checker on the wires of one host-to-device link.
// Assumes both ends run on ref_clk.
`default_nettype none
module latch_link_checker (
  // Clock
  input wire logic ref_clk,
  input wire logic arst_n,
  // Link
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic latch_load_strobe,
  input wire logic status_mux_output
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  logic sclk_q;
  logic [5:0] n_rise;
  // Counts link clock rises within one frame
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_q <= 1'b0;
      n_rise <= 6'h00;
    end else begin
      sclk_q <= serial_clk;
      if (latch_load_strobe) n_rise <= 6'h00;
      else if (serial_clk && !sclk_q) n_rise <= n_rise + 6'h01;
    end
  end
  a_sclk_high: assert property ($rose(serial_clk) |-> serial_clk [*4])
    else $error("clock high too short");
  a_sclk_low: assert property ($fell(serial_clk) |-> !serial_clk [*4])
    else $error("clock low too short");
  a_rise_framed: assert property ($rose(serial_clk) |-> !latch_load_strobe)
    else $error("clock rise outside frame");
  a_data_steady: assert property (serial_clk |-> $stable(serial_data))
    else $error("data moved while clock high");
  a_idle_quiet: assert property (latch_load_strobe |-> !serial_clk)
    else $error("clock high while idle");
  a_word_bits: assert property ($rose(latch_load_strobe) |-> n_rise == 6'h18)
    else $error("frame not 24 bits");
  a_first_edge: assert property ($fell(latch_load_strobe) |-> ##[1:8] $rose(serial_clk))
    else $error("no clock after frame open");
  a_frame_end: assert property ($fell(latch_load_strobe) |-> ##[180:210] latch_load_strobe)
    else $error("frame not closed");
  c_load: cover property ($rose(latch_load_strobe));
  c_lock_on: cover property ($rose(status_mux_output));
  c_lock_off: cover property ($fell(status_mux_output));
endmodule : latch_link_checker
`default_nettype wire

// [latch_link_if.sv]
// Three-wire link between host and latch loader device, plus status pin.
// Assumes the bench drives no extra wires.
`default_nettype none
interface latch_link_if;
  timeunit 1ns;
  timeprecision 1ns;
  logic serial_clk;
  logic serial_data;
  logic latch_load_strobe;
  logic status_mux_output;
  modport host (output serial_clk, output serial_data, output latch_load_strobe,
    input status_mux_output);
  modport device (input serial_clk, input serial_data, input latch_load_strobe,
    output status_mux_output);
endinterface : latch_link_if
`default_nettype wire

// [latch_loader_device.sv]
// Device end: shifts serial words and loads them into addressed latches.
// Assumes link pins are asynchronous to ref_clk; they are synchronised here.
// What this block does
// - Shift data on each serial clock rise
// - Strobe rise loads 24 bits into latch
// - Host keeps serial clock at most 20 MHz
// - Write only; no readback of latches
// - Host drops strobe before shifting word
// - Host sends three bytes per word
// - Host raises strobe after third byte
// - Host keeps data stable on rising edge
// - Status pin shows lock when configured
// - Select bits 01 pick reference counter
`default_nettype none
module latch_loader_device (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Link
  latch_link_if.device link,
  // User side
  input wire logic lock_detect,
  input wire logic status_sel_lock,
  output logic [23:0] control_latch,
  output logic [23:0] ref_counter_latch,
  output logic [23:0] n_counter_latch,
  output logic [23:0] test_latch,
  output logic load_pulse
);
  timeunit 1ns;
  timeprecision 1ns;

  // Frame tracking, one-hot
  typedef enum logic [2:0] {
    ST_WAIT = 3'h1,
    ST_FRAME = 3'h2,
    ST_LOAD = 3'h4
  } frame_state_t;
  frame_state_t frame_state;

  // Synchronisers
  logic [2:0] clk_sync;
  logic [1:0] le_sync;
  logic [1:0] dat_sync;
  logic [1:0] lock_sync;
  logic [1:0] sel_lock_sync;

  // Shift and load path
  logic clk_rise;
  logic load_now;
  logic [23:0] shift;
  logic [1:0] sel;
  logic lock_q;

  // True when the word's select bits name this latch
  function automatic logic sel_hit(input logic [1:0] sel_bits, input logic [1:0] code);
    return sel_bits == code;
  endfunction : sel_hit

  // Link clock; the third stage only marks edges
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_sync <= {3{latch_loader_pkg::SCLK_IDLE}};
    end else begin
      clk_sync <= {clk_sync[1:0], link.serial_clk};
    end
  end

  // Strobe idles high; resetting there avoids a false rise
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      le_sync <= {2{latch_loader_pkg::STROBE_IDLE}};
    end else begin
      le_sync <= {le_sync[0], link.latch_load_strobe};
    end
  end

  // Serial data, aligned with the clock synchroniser
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dat_sync <= 2'h0;
    end else begin
      dat_sync <= {dat_sync[0], link.serial_data};
    end
  end

  // Lock level from the loop, asynchronous here
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      lock_sync <= 2'h0;
    end else begin
      lock_sync <= {lock_sync[0], lock_detect};
    end
  end

  // Status select level
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_lock_sync <= 2'h0;
    end else begin
      sel_lock_sync <= {sel_lock_sync[0], status_sel_lock};
    end
  end

  assign clk_rise = clk_sync[1] && !clk_sync[2];

  // Sample on rise; oldest bits fall off
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      shift <= latch_loader_pkg::WORD_RESET;
    end else if (clk_rise) begin
      shift <= {shift[22:0], dat_sync[1]};
    end
  end

  assign sel = shift[latch_loader_pkg::SEL_LSB +: 2];

  // Frame opens low, closes on rise
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      frame_state <= ST_WAIT;
    end else begin
      case (frame_state)
        ST_WAIT: begin
          if (!le_sync[1]) begin
            frame_state <= ST_FRAME;
          end
        end
        ST_FRAME: begin
          if (le_sync[1]) begin
            frame_state <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          frame_state <= ST_WAIT;
        end
        default: begin
          frame_state <= ST_WAIT;
        end
      endcase
    end
  end

  assign load_now = (frame_state == ST_FRAME) && le_sync[1];

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      load_pulse <= 1'b0;
    end else begin
      load_pulse <= load_now;
    end
  end

  // Latches only written, never read back
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      control_latch <= latch_loader_pkg::WORD_RESET;
    end else if (load_now) begin
      if (sel_hit(sel, latch_loader_pkg::SEL_CONTROL)) begin
        control_latch <= shift;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_counter_latch <= latch_loader_pkg::WORD_RESET;
    end else if (load_now) begin
      if (sel_hit(sel, latch_loader_pkg::SEL_REF_COUNTER)) begin
        ref_counter_latch <= shift;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      n_counter_latch <= latch_loader_pkg::WORD_RESET;
    end else if (load_now) begin
      if (sel_hit(sel, latch_loader_pkg::SEL_N_COUNTER)) begin
        n_counter_latch <= shift;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      test_latch <= latch_loader_pkg::WORD_RESET;
    end else if (load_now) begin
      if (sel_hit(sel, latch_loader_pkg::SEL_TEST)) begin
        test_latch <= shift;
      end
    end
  end

  // Lock on status pin when selected
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      lock_q <= 1'b0;
    end else begin
      lock_q <= sel_lock_sync[1] && lock_sync[1];
    end
  end
  assign link.status_mux_output = lock_q;
endmodule : latch_loader_device
`default_nettype wire

// [latch_loader_host.sv]
// Host end: sends one 24-bit word as three bytes, then raises the strobe.
// Assumes status pin is asynchronous; it is synchronised before use.
`default_nettype none
module latch_loader_host (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Link
  latch_link_if.host link,
  // User side
  input wire logic send_req,
  input wire logic [23:0] send_word,
  output logic busy,
  output logic locked
);
  timeunit 1ns;
  timeprecision 1ns;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_LOW = 4'b0010,
    ST_HIGH = 4'b0100,
    ST_LOAD = 4'b1000
  } state_t;
  state_t state;
  logic [3:0] div;
  logic [4:0] bit_cnt;
  logic [23:0] word;
  logic sclk, sdat, strobe;
  logic [1:0] lock_sync;
  logic tick;
  assign tick = (div == latch_loader_pkg::DIV_LAST);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      div <= 4'h0;
    end else if (state == ST_IDLE || tick) begin
      div <= 4'h0;
    end else begin
      div <= div + 4'h1;
    end
  end

  // Strobe low opens; 24 bits MSB first; strobe high ends
  // Divider keeps clock under limit; data changes on falling edge
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      bit_cnt <= 5'h0;
      word <= latch_loader_pkg::WORD_RESET;
      sclk <= latch_loader_pkg::SCLK_IDLE;
      sdat <= 1'b0;
      strobe <= latch_loader_pkg::STROBE_IDLE;
      busy <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (send_req) begin
            word <= {send_word[22:0], 1'b0};
            sdat <= send_word[23];
            strobe <= 1'b0;
            bit_cnt <= 5'h0;
            busy <= 1'b1;
            state <= ST_LOW;
          end
        end
        ST_LOW: if (tick) begin
          sclk <= 1'b1;
          state <= ST_HIGH;
        end
        ST_HIGH: if (tick) begin
          sclk <= 1'b0;
          if (bit_cnt == latch_loader_pkg::BIT_LAST) begin
            state <= ST_LOAD;
          end else begin
            sdat <= word[23];
            word <= {word[22:0], 1'b0};
            bit_cnt <= bit_cnt + 5'h1;
            state <= ST_LOW;
          end
        end
        ST_LOAD: if (tick) begin
          strobe <= 1'b1;
          busy <= 1'b0;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
  assign link.serial_clk = sclk;
  assign link.serial_data = sdat;
  assign link.latch_load_strobe = strobe;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      lock_sync <= 2'h0;
      locked <= 1'b0;
    end else begin
      lock_sync <= {lock_sync[0], link.status_mux_output};
      locked <= lock_sync[1];
    end
  end
endmodule : latch_loader_host
`default_nettype wire

// [latch_loader_pkg.sv]
// Shared constants for the three-wire latch loader link.
// Assumes both ends run on ref_clk at 25 MHz.
`default_nettype none
package latch_loader_pkg;
  localparam int WORD_BITS = 24;
  localparam int BYTE_BITS = 8;
  localparam int BYTES_PER_WORD = 3;
  localparam int SEL_LSB = 0;
  localparam logic [1:0] SEL_CONTROL = 2'h0;
  localparam logic [1:0] SEL_REF_COUNTER = 2'h1;
  localparam logic [1:0] SEL_N_COUNTER = 2'h2;
  localparam logic [1:0] SEL_TEST = 2'h3;
  localparam int CLK_HZ = 25_000_000;
  localparam int SCLK_MAX_HZ = 20_000_000;
  // Half period of the link clock in ref_clk cycles; never faster than SCLK_MAX_HZ
  localparam int SCLK_HALF_MIN = (CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
  localparam int SCLK_HALF = (SCLK_HALF_MIN < 4) ? 4 : SCLK_HALF_MIN;
  localparam logic [3:0] DIV_LAST = 4'(SCLK_HALF - 1);
  localparam logic [4:0] BIT_LAST = 5'(WORD_BITS - 1);
  localparam logic [23:0] WORD_RESET = 24'h0000_00;
  // Idle levels of the link pins that carry edges
  localparam logic SCLK_IDLE = 1'b0;
  localparam logic STROBE_IDLE = 1'b1;
endpackage : latch_loader_pkg
`default_nettype wire

// [three_wire_latch_loader_tb.sv]
// Bench: host end loads words into device end over one link.
// Assumes the design package and interface are compiled first.
`default_nettype none
module three_wire_latch_loader_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic lock_detect = 1'b0;
  logic status_sel_lock = 1'b1;
  logic send_req = 1'b0;
  logic [23:0] send_word = 24'h0000_00;
  logic [23:0] ctl, refc, ncnt, tst, e;
  logic load_pulse, busy, locked;
  logic [31:0] seed = 32'h0000_002b;
  logic [23:0] q[$];
  int miscompares = 0;
  int n_compared = 0;
  latch_link_if link ();
  latch_loader_host u_latch_loader_host (.ref_clk(ref_clk), .arst_n(arst_n), .link(link),
    .send_req(send_req), .send_word(send_word), .busy(busy), .locked(locked));
  latch_loader_device u_latch_loader_device (.ref_clk(ref_clk), .arst_n(arst_n),
    .link(link), .lock_detect(lock_detect), .status_sel_lock(status_sel_lock),
    .control_latch(ctl), .ref_counter_latch(refc), .n_counter_latch(ncnt),
    .test_latch(tst), .load_pulse(load_pulse));
  latch_link_checker u_latch_link_checker (.ref_clk(ref_clk), .arst_n(arst_n),
    .serial_clk(link.serial_clk), .serial_data(link.serial_data),
    .latch_load_strobe(link.latch_load_strobe), .status_mux_output(link.status_mux_output));
  always #20 ref_clk = ~ref_clk;
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic chk(string what, logic [23:0] exp, logic [23:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chk_bit(string what, logic exp, logic got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  task automatic send(logic [23:0] w);
    @(posedge ref_clk) #1;
    send_req = 1'b1;
    send_word = w;
    q.push_back(w);
    @(posedge ref_clk) #1;
    send_req = 1'b0;
    chk_bit("busy", 1'b1, busy);
    chk_bit("strobe", 1'b0, link.latch_load_strobe);
    repeat (300) if (busy !== 1'b0) @(posedge ref_clk) #1;
  endtask : send
  // Each load takes the oldest word and lands in the latch it selects
  always @(negedge ref_clk) begin
    if (load_pulse === 1'b1) begin
      e = (q.size() > 0) ? q.pop_front() : 24'hFFFF_FF;
      case (e[1:0])
        latch_loader_pkg::SEL_CONTROL: chk("control", e, ctl);
        latch_loader_pkg::SEL_REF_COUNTER: chk("refcount", e, refc);
        latch_loader_pkg::SEL_N_COUNTER: chk("ncount", e, ncnt);
        default: chk("test", e, tst);
      endcase
    end
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    #1 arst_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      void'(xs());
      send({seed[23:2], i[1:0]});
      $display("test word %0d done", i);
    end
    for (int i = 0; i < 8; i++) begin
      lock_detect = ~lock_detect;
      status_sel_lock = ~i[1];
      repeat (8) @(posedge ref_clk);
      #1 chk_bit("locked", lock_detect && status_sel_lock, locked);
      $display("test lock %0d done", i);
    end
    chk_bit("drained", 1'b1, q.size() == 0);
    conclude();
  end
  initial begin
    #200_000;
    miscompares++;
    conclude();
  end
endmodule : three_wire_latch_loader_tb
`default_nettype wire
